// ===== pkg/bus_sizing_map.vh
/*
 * Constants for the dynamic bus sizing multiplexer: remaining-size codes,
 * width-acknowledge codes and byte counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef BUS_SIZING_MAP_VH
`define BUS_SIZING_MAP_VH

// ----------------------------------------------------------------------
// Remaining-size codes
// ----------------------------------------------------------------------
`define SIZE_BYTE 2'h1
`define SIZE_WORD 2'h2
`define SIZE_THREE 2'h3
`define SIZE_LONG 2'h0

// ----------------------------------------------------------------------
// Width-acknowledge codes {hi, lo}
// ----------------------------------------------------------------------
`define ACK_WAIT 2'h0
`define ACK_PORT8 2'h1
`define ACK_PORT16 2'h2
`define ACK_PORT32 2'h3

// ----------------------------------------------------------------------
// Byte counts and the top lane index
// ----------------------------------------------------------------------
`define BYTES_NONE 3'h0
`define BYTES_ONE 3'h1
`define BYTES_TWO 3'h2
`define BYTES_FOUR 3'h4
`define LANE_TOP 2'h0

`endif

// ===== design/write_lane_mux.v
/*
 * Write-cycle lane multiplexer: places operand bytes onto the four data lanes.
 * Assumes a combinational caller; operand bytes msb..lsb in operand[31:0].
 */
`timescale 1ns/1ps
`include "bus_sizing_map.vh"
module write_lane_mux
(
    input wire [1:0] size_code,
    input wire [1:0] offset,
    input wire [31:0] operand,
    output reg [31:0] lanes
);
    wire [7:0] op_msb = operand[31:24];
    wire [7:0] op_2nd = operand[23:16];
    wire [7:0] op_3rd = operand[15:8];
    wire [7:0] op_lsb = operand[7:0];

    // ------------------------------------------------------------------
    // Lane pattern by size code and offset
    // ------------------------------------------------------------------
    always @*
    begin
        lanes = {op_msb, op_2nd, op_3rd, op_lsb};
        case (size_code)
            `SIZE_BYTE: lanes = {4{op_lsb}};
            `SIZE_WORD:
            begin
                if (offset[0])
                    lanes = {op_3rd, op_3rd, op_lsb, op_3rd};
                else
                    lanes = {op_3rd, op_lsb, op_3rd, op_lsb};
            end
            `SIZE_THREE:
            begin
                case (offset)
                    2'h0: lanes = {op_2nd, op_3rd, op_lsb, op_msb};
                    2'h1: lanes = {op_2nd, op_2nd, op_3rd, op_lsb};
                    2'h2: lanes = {op_2nd, op_3rd, op_2nd, op_3rd};
                    default: lanes = {op_2nd, op_2nd, op_3rd, op_2nd};
                endcase
            end
            default:
            begin
                case (offset)
                    2'h0: lanes = {op_msb, op_2nd, op_3rd, op_lsb};
                    2'h1: lanes = {op_msb, op_msb, op_2nd, op_3rd};
                    2'h2: lanes = {op_msb, op_2nd, op_msb, op_2nd};
                    default: lanes = {op_msb, op_msb, op_2nd, op_msb};
                endcase
            end
        endcase
    end
endmodule // write_lane_mux

// ===== design/dynamic_bus_sizing_mux.v
/*
 * Processor-side data multiplexer and cycle sequencer for a 32-bit bus with
 * dynamic port sizing. Splits one operand into as many bus cycles as needed.
 * Assumes acks and read data arrive asynchronously and are synchronised here;
 * read data is stable on the lanes before the acknowledge is seen.
 */
`timescale 1ns/1ps
`include "bus_sizing_map.vh"
module dynamic_bus_sizing_mux
(
    input wire ref_clk,
    input wire rst_b,
    input wire req_valid,
    input wire req_write,
    input wire req_prefetch,
    input wire [1:0] req_size,
    input wire [31:0] req_addr,
    input wire [31:0] req_wdata,
    output reg req_ready,
    output reg done,
    output reg addr_error,
    output reg misaligned,
    output reg [31:0] rdata,
    output reg bus_cycle,
    output reg bus_write,
    output reg [31:0] bus_addr,
    output reg remaining_size_hi,
    output reg remaining_size_lo,
    output reg [31:0] bus_data_out,
    output reg bus_data_oe_b,
    input wire [31:0] bus_data_in,
    input wire width_ack_hi,
    input wire width_ack_lo
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RUN = 3'b010;
    localparam [2:0] ST_RECOVER = 3'b100;

    reg [2:0] state;
    reg [2:0] remain;
    reg [31:0] operand;
    reg ack_hi_s1;
    reg ack_hi_s2;
    reg ack_lo_s1;
    reg ack_lo_s2;
    reg [31:0] data_s1;
    reg [31:0] data_s2;

    reg [2:0] next_state;
    reg [2:0] next_remain;
    reg [31:0] next_addr;
    reg [31:0] next_operand;
    reg [2:0] room;
    reg [2:0] moved;
    reg [1:0] lane_base;
    reg start;
    reg fault;
    reg is_misaligned;
    reg acked;
    reg finish;
    wire [1:0] ack_code = {ack_hi_s2, ack_lo_s2};
    wire [2:0] first_byte = `BYTES_FOUR - remain;
    wire [31:0] write_lanes;
    wire [31:0] read_merge;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ack_hi_s1 <= 1'b0;
            ack_hi_s2 <= 1'b0;
            ack_lo_s1 <= 1'b0;
            ack_lo_s2 <= 1'b0;
            data_s1 <= 32'h0000_0000;
            data_s2 <= 32'h0000_0000;
        end
        else
        begin
            ack_hi_s1 <= width_ack_hi;
            ack_hi_s2 <= ack_hi_s1;
            ack_lo_s1 <= width_ack_lo;
            ack_lo_s2 <= ack_lo_s1;
            data_s1 <= bus_data_in;
            data_s2 <= data_s1;
        end
    end

    // ------------------------------------------------------------------
    // Bytes this cycle can move for the answered port width
    // ------------------------------------------------------------------
    always @*
    begin
        room = `BYTES_FOUR - {1'b0, bus_addr[1:0]};
        lane_base = bus_addr[1:0];
        case (ack_code)
            `ACK_PORT8:
            begin
                room = `BYTES_ONE;
                lane_base = `LANE_TOP;
            end
            `ACK_PORT16:
            begin
                room = `BYTES_TWO - {2'b00, bus_addr[0]};
                lane_base = {1'b0, bus_addr[0]};
            end
            default:
            begin
                room = `BYTES_FOUR - {1'b0, bus_addr[1:0]};
                lane_base = bus_addr[1:0];
            end
        endcase
        moved = (remain < room) ? remain : room;
    end

    // ------------------------------------------------------------------
    // Read byte capture, one slice per operand byte
    // ------------------------------------------------------------------
    genvar j;
    generate
        for (j = 0; j < 4; j = j + 1)
        begin : g_read
            localparam integer SLOT = j;
            wire [2:0] idx = SLOT[2:0];
            wire [2:0] pos = idx - first_byte;
            wire take = (idx >= first_byte) && (pos < moved);
            wire [1:0] lane = lane_base + pos[1:0];
            wire [7:0] lane_byte = data_s2[31 - 8 * lane -: 8];
            assign read_merge[31 - 8 * j -: 8] =
                take ? lane_byte : operand[31 - 8 * j -: 8];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always @*
    begin
        next_state = state;
        next_remain = remain;
        next_addr = bus_addr;
        next_operand = operand;
        start = 1'b0;
        fault = 1'b0;
        acked = 1'b0;
        finish = 1'b0;
        is_misaligned = 1'b0;
        case (req_size)
            `SIZE_WORD: is_misaligned = req_addr[0];
            `SIZE_LONG: is_misaligned = |req_addr[1:0];
            default: is_misaligned = 1'b0;
        endcase
        case (state)
            ST_IDLE:
            begin
                if (req_valid && req_prefetch && req_addr[0])
                    fault = 1'b1;
                else if (req_valid)
                begin
                    start = 1'b1;
                    next_state = ST_RUN;
                    next_addr = req_addr;
                    next_operand = req_write ? req_wdata : 32'h0000_0000;
                    next_remain = (req_size == `SIZE_LONG) ? `BYTES_FOUR
                        : {1'b0, req_size};
                end
            end
            ST_RUN:
            begin
                if (ack_code != `ACK_WAIT)
                begin
                    acked = 1'b1;
                    next_state = ST_RECOVER;
                    next_remain = remain - moved;
                    next_addr = bus_addr + {29'h0000_0000, moved};
                    if (!bus_write)
                        next_operand = read_merge;
                end
            end
            ST_RECOVER:
            begin
                if (ack_code == `ACK_WAIT)
                begin
                    if (remain == `BYTES_NONE)
                    begin
                        finish = 1'b1;
                        next_state = ST_IDLE;
                    end
                    else
                    begin
                        start = 1'b1;
                        next_state = ST_RUN;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Write lanes for the cycle about to start
    // ------------------------------------------------------------------
    write_lane_mux u_lanes
    (
        .size_code(next_remain[1:0]),
        .offset(next_addr[1:0]),
        .operand(next_operand),
        .lanes(write_lanes)
    );

    // ------------------------------------------------------------------
    // Registered sequencer state
    // ------------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            state <= ST_IDLE;
            remain <= `BYTES_NONE;
            operand <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
            remain <= next_remain;
            operand <= next_operand;
        end
    end

    // ------------------------------------------------------------------
    // Request-side outputs
    // ------------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            req_ready <= 1'b0;
            done <= 1'b0;
            addr_error <= 1'b0;
            misaligned <= 1'b0;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            req_ready <= (next_state == ST_IDLE);
            done <= finish;
            addr_error <= fault;
            if (start && state == ST_IDLE)
                misaligned <= is_misaligned;
            if (finish && !bus_write)
                rdata <= operand;
        end
    end

    // ------------------------------------------------------------------
    // Bus-side outputs
    // ------------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            bus_cycle <= 1'b0;
            bus_write <= 1'b0;
            bus_addr <= 32'h0000_0000;
            remaining_size_hi <= 1'b0;
            remaining_size_lo <= 1'b0;
            bus_data_out <= 32'h0000_0000;
            bus_data_oe_b <= 1'b1;
        end
        else
        begin
            bus_addr <= next_addr;
            if (start && state == ST_IDLE)
                bus_write <= req_write;
            if (start)
            begin
                bus_cycle <= 1'b1;
                remaining_size_hi <= next_remain[1];
                remaining_size_lo <= next_remain[0];
                bus_data_out <= write_lanes;
                bus_data_oe_b <= !((state == ST_IDLE) ? req_write : bus_write);
            end
            else if (acked)
            begin
                bus_cycle <= 1'b0;
                bus_data_oe_b <= 1'b1;
            end
        end
    end
endmodule // dynamic_bus_sizing_mux

// ===== testbench/bus_sizing_sva.sv
/* Checker on the ports of the bus sizing multiplexer.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module bus_sizing_sva
(
    input wire ref_clk,
    input wire rst_b,
    input wire req_valid,
    input wire req_ready,
    input wire req_prefetch,
    input wire [1:0] req_size,
    input wire [31:0] req_addr,
    input wire addr_error,
    input wire misaligned,
    input wire bus_cycle,
    input wire bus_write,
    input wire [31:0] bus_addr,
    input wire remaining_size_hi,
    input wire remaining_size_lo,
    input wire [31:0] bus_data_out,
    input wire bus_data_oe_b,
    input wire width_ack_hi,
    input wire width_ack_lo
);
// ------------------------------------------------------------
// Properties
// ------------------------------------------------------------
// Shorthands for requests and the bus side
wire [1:0] sz = {remaining_size_hi, remaining_size_lo};
wire [31:0] d = bus_data_out;
wire take = req_valid && req_ready;
wire go = take && !req_prefetch;
wire odd_fetch = take && req_prefetch && req_addr[0];
wire wr = bus_cycle && bus_write;
wire no_ack = !width_ack_hi && !width_ack_lo;
wire mis = req_size == 2'h2 ? req_addr[0] : req_size == 2'h0 && req_addr[1:0] != 2'h0;
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!rst_b);
fetch_refuse_a: assert property (odd_fetch |=> addr_error && !bus_cycle)
    else $error("odd fetch reached the bus");
first_cycle_a:
    assert property (go |=> bus_cycle && bus_addr == $past(req_addr) && sz == $past(req_size))
    else $error("first cycle wrong");
align_flag_a: assert property (go && req_size != 2'h3 |=> misaligned == $past(mis))
    else $error("alignment flag wrong");
byte_copy_a: assert property (wr && sz == 2'h1 |-> d == {4{d[7:0]}})
    else $error("byte not on all lanes");
word_even_a: assert property (wr && sz == 2'h2 && !bus_addr[0] |-> d[31:16] == d[15:0])
    else $error("even word lanes wrong");
word_odd_a:
    assert property (wr && sz == 2'h2 && bus_addr[0] |-> d[31:24] == d[23:16] && d[7:0] == d[31:24])
    else $error("odd word lanes wrong");
lane_drive_a: assert property (bus_cycle |-> bus_data_oe_b == !bus_write)
    else $error("lane drive wrong");
wait_hold_a: assert property (no_ack [*4] ##0 bus_cycle |=> bus_cycle)
    else $error("cycle ended without ack");
// Main scenarios
cover property (odd_fetch);
cover property (wr && sz == 2'h3);
cover property (bus_cycle && width_ack_hi && !width_ack_lo);
endmodule // bus_sizing_sva
bind dynamic_bus_sizing_mux bus_sizing_sva u_bus_sizing_sva (.*);

// ===== testbench/port_model.sv
/* Model of an 8-, 16- or 32-bit slave port with wait states.
   Assumes the bench sets port_code and wait_cnt between operations. */
`timescale 1ns/1ps
`include "bus_sizing_map.vh"
module port_model
(
    input wire ref_clk,
    input wire [1:0] port_code,
    input wire [3:0] wait_cnt,
    input wire bus_cycle,
    input wire bus_write,
    input wire [31:0] bus_addr,
    input wire remaining_size_hi,
    input wire remaining_size_lo,
    input wire [31:0] bus_data_out,
    output logic [31:0] bus_data_in,
    output logic width_ack_hi,
    output logic width_ack_lo
);
// ------------------------------------------------------------
// Slave behaviour
// ------------------------------------------------------------
logic [65:0] log_q[$];
logic [31:0] a;
logic [31:0] d;
// Memory byte held at an address
function automatic [7:0] mb(input [31:0] x);
    mb = 8'h10 + x[7:0];
endfunction
// Log each cycle, answer it, release ack and data once it ends
initial
begin
    {bus_data_in, width_ack_hi, width_ack_lo} = 34'h0;
    forever
    begin
        @(posedge ref_clk);
        #1;
        if (bus_cycle === 1'b1)
        begin
            a = bus_addr;
            log_q.push_back({a, remaining_size_hi, remaining_size_lo,
                bus_write ? bus_data_out : 32'h0});
            d = ~bus_data_in;
            if (port_code == `ACK_PORT32)
                d = {mb(a & 32'hFFFFFFFC), mb(a | 32'h1), mb(a | 32'h2), mb(a | 32'h3)};
            else if (port_code == `ACK_PORT16)
                d[31:16] = {mb(a & 32'hFFFFFFFE), mb(a | 32'h1)};
            else
                d[31:24] = mb(a);
            bus_data_in = d;
            repeat (wait_cnt + 1) @(posedge ref_clk);
            #1;
            {width_ack_hi, width_ack_lo} = port_code;
            while (bus_cycle === 1'b1)
            begin
                @(posedge ref_clk);
                #1;
            end
            {width_ack_hi, width_ack_lo} = `ACK_WAIT;
            bus_data_in = ~d;
        end
    end
end
endmodule // port_model

// ===== testbench/dynamic_bus_sizing_mux_tb_top.sv
/* Self-checking bench for the bus sizing multiplexer and a port model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`include "bus_sizing_map.vh"
module dynamic_bus_sizing_mux_tb_top;
// ------------------------------------------------------------
// Signals and instances
// ------------------------------------------------------------
logic ref_clk, rst_b, req_valid, req_write, req_prefetch;
logic [1:0] req_size, port_code;
logic [3:0] wait_cnt;
logic [31:0] req_addr, req_wdata;
wire req_ready, done, addr_error, misaligned, bus_cycle, bus_write, bus_data_oe_b;
wire remaining_size_hi, remaining_size_lo, width_ack_hi, width_ack_lo;
wire [31:0] rdata, bus_addr, bus_data_out, bus_data_in;
integer error_cnt = 0;
integer compares = 0;
dynamic_bus_sizing_mux u_dynamic_bus_sizing_mux (.*);
port_model u_port_model (.*);
// Clock at 100 MHz
initial
begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
end
// ------------------------------------------------------------
// Shared tasks
// ------------------------------------------------------------
task automatic check(input [65:0] seen, input [65:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic results;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
// One operand request, held for a single cycle, then a bounded wait
task automatic req(input w, input pf, input [1:0] sz, input [31:0] a, input [31:0] wd);
    integer n;
    for (n = 0; n < 20 && req_ready !== 1'b1; n++)
        @(negedge ref_clk);
    u_port_model.log_q.delete();
    @(posedge ref_clk);
    req_valid <= 1'b1;
    {req_write, req_prefetch, req_size, req_addr, req_wdata} <= {w, pf, sz, a, wd};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    for (n = 0; n < 400 && done !== 1'b1 && addr_error !== 1'b1; n++)
        @(negedge ref_clk);
    check(n < 400, 1'b1);
endtask
task automatic cyc(input integer i, input [31:0] a, input [1:0] s, input [31:0] d);
    check(u_port_model.log_q[i], {a, s, d});
endtask
task automatic ncyc(input integer n);
    check(u_port_model.log_q.size(), n);
endtask
// ------------------------------------------------------------
// Scenarios
// ------------------------------------------------------------
task automatic t_word16;
    port_code <= `ACK_PORT16;
    req(1'b1, 1'b0, `SIZE_LONG, 32'h200, 32'h11223344);
    ncyc(2);
    cyc(0, 32'h200, 2'h0, 32'h11223344);
    cyc(1, 32'h202, 2'h2, 32'h33443344);
    check(misaligned, 1'b0);
    wait_cnt <= 4'h3;
    req(1'b1, 1'b0, `SIZE_LONG, 32'h201, 32'h11223344);
    ncyc(3);
    cyc(0, 32'h201, 2'h0, 32'h11112233);
    cyc(1, 32'h202, 2'h3, 32'h22332233);
    cyc(2, 32'h204, 2'h1, 32'h44444444);
    check(misaligned, 1'b1);
    check(done, 1'b1);
    $display("test word port writes ended");
endtask
task automatic t_byte32;
    port_code <= `ACK_PORT8;
    wait_cnt <= 4'h1;
    req(1'b1, 1'b0, `SIZE_WORD, 32'h200, 32'h0000A5C3);
    cyc(0, 32'h200, 2'h2, 32'hA5C3A5C3);
    cyc(1, 32'h201, 2'h1, 32'hC3C3C3C3);
    port_code <= `ACK_PORT32;
    req(1'b1, 1'b0, `SIZE_WORD, 32'h203, 32'h0000A5C3);
    cyc(0, 32'h203, 2'h2, 32'hA5A5C3A5);
    cyc(1, 32'h204, 2'h1, 32'hC3C3C3C3);
    req(1'b1, 1'b0, `SIZE_THREE, 32'h301, 32'h00223344);
    ncyc(1);
    cyc(0, 32'h301, 2'h3, 32'h22223344);
    $display("test byte and long port writes ended");
endtask
task automatic t_reads;
    req(1'b0, 1'b0, `SIZE_LONG, 32'h100, 32'h0);
    check(rdata, 32'h10111213);
    ncyc(1);
    req(1'b0, 1'b0, `SIZE_BYTE, 32'h102, 32'h0);
    check(rdata, 32'h00000012);
    port_code <= `ACK_PORT16;
    req(1'b0, 1'b0, `SIZE_LONG, 32'h101, 32'h0);
    check(rdata, 32'h11121314);
    cyc(1, 32'h102, 2'h3, 32'h0);
    port_code <= `ACK_PORT8;
    req(1'b0, 1'b0, `SIZE_WORD, 32'h103, 32'h0);
    check(rdata, 32'h00001314);
    ncyc(2);
    $display("test reads ended");
endtask
task automatic t_fetch;
    port_code <= `ACK_PORT32;
    req(1'b0, 1'b1, `SIZE_LONG, 32'h103, 32'h0);
    check(addr_error, 1'b1);
    ncyc(0);
    req(1'b0, 1'b1, `SIZE_LONG, 32'h100, 32'h0);
    check(rdata, 32'h10111213);
    $display("test prefetch ended");
endtask
// Reset for three cycles, then the scenarios
initial
begin
    {rst_b, req_valid, req_write, req_prefetch, req_size, port_code} = 8'h0;
    {req_addr, req_wdata, wait_cnt} = 68'h0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_word16;
    t_byte32;
    t_reads;
    t_fetch;
    results;
end
// Watchdog, far beyond the few hundred cycles the scenarios need
initial
begin
    #100000;
    error_cnt = error_cnt + 1;
    results;
end
endmodule // dynamic_bus_sizing_mux_tb_top
